// ==== src/dmc_pkg.sv ====
// constants shared by the display channel mode control block
package dmc_pkg;

    // register bus geometry
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;

    // register offsets
    localparam logic [3:0] OFS_MODE_CONTROL = 4'h0;
    localparam logic [3:0] OFS_BUFFER_POINTER = 4'h1;
    localparam logic [3:0] OFS_TRANSMIT_HOLD = 4'h2;
    localparam logic [3:0] OFS_BUFFER_DATA_PORT = 4'h3;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h5;

    // ddc_mode_control field positions
    localparam int BIT_BUFFER_SIZE_SELECT = 6;
    localparam int BIT_SOFTWARE_HANDLING_SELECT = 5;
    localparam int BIT_RELOAD_REQUEST_FLAG = 3;
    localparam int BIT_ONE_WAY_ENABLE = 2;
    localparam int BIT_MODE_SWITCH_FLAG = 1;
    localparam int BIT_MODE_INDICATOR = 0;
    // writable bits; bits 7 and 4 stay zero
    localparam logic [7:0] MODE_CONTROL_WMASK = 8'h6f;

    // irq status and mask field positions
    localparam int IRQ_BIT_RELOAD = 0;
    localparam int IRQ_BIT_SWITCH = 1;
    localparam logic [7:0] IRQ_WMASK = 8'h03;

    // reset values
    localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] BUFFER_POINTER_RESET = 8'h00;
    localparam logic [7:0] TRANSMIT_HOLD_RESET = 8'h00;
    localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

    // upper limit of the small identification area
    localparam logic [7:0] SMALL_AREA_LIMIT = 8'h7f;

    // interrupt vector shared by both flags
    localparam logic [15:0] IRQ_VECTOR = 16'h002b;

    // one-way link timing, counted in link clock rising edges
    localparam logic [3:0] SYNC_EDGES = 4'h9;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] NINTH_BIT = 4'h8;

    typedef enum logic [0:0] {
        DMC_SYNC,
        DMC_SEND
    } dmc_tx_state_t;

endpackage

// ==== src/dmc_one_way_tx.sv ====
// one-way transmitter clocked by edges of the sampled link clock
`timescale 1ns/1ns
`default_nettype none

module dmc_one_way_tx (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic run_in,
    input wire logic one_way_link_clock_in,
    input wire logic [7:0] hold_in,
    output logic reload_req_out,
    output logic data_pin_out,
    output logic data_pin_oe_out
);

    ////////////////////////////////////////////////////////////////
    // link clock synchroniser and rising edge detect
    logic link_meta;
    logic link_sync;
    logic link_prev;
    logic link_rise;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link_meta <= 1'b0;
            link_sync <= 1'b0;
            link_prev <= 1'b0;
        end else begin
            link_meta <= one_way_link_clock_in;
            link_sync <= link_meta;
            link_prev <= link_sync;
        end
    end

    assign link_rise = link_sync & ~link_prev;

    ////////////////////////////////////////////////////////////////
    // byte sequencer
    dmc_pkg::dmc_tx_state_t state;
    dmc_pkg::dmc_tx_state_t next_state;
    logic [3:0] count;
    logic [3:0] next_count;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic data;
    logic next_data;
    logic oe;
    logic next_oe;
    logic req;
    logic next_req;

    always_comb begin
        next_state = state;
        next_count = count;
        next_shift = shift;
        next_data = data;
        next_oe = oe;
        next_req = 1'b0;
        if (!run_in) begin
            // link clock activity is ignored while stopped
            next_state = dmc_pkg::DMC_SYNC;
            next_count = 4'h0;
            next_oe = 1'b0;
            next_data = 1'b0;
        end else if (link_rise) begin
            case (state)
                dmc_pkg::DMC_SYNC: begin
                    next_oe = 1'b0;
                    if (count == dmc_pkg::SYNC_EDGES - 4'h1) begin
                        // ask for the first byte before the 10th edge
                        next_req = 1'b1;
                        next_state = dmc_pkg::DMC_SEND;
                        next_count = dmc_pkg::NINTH_BIT;
                    end else begin
                        next_count = count + 4'h1;
                    end
                end
                dmc_pkg::DMC_SEND: begin
                    if (count == dmc_pkg::NINTH_BIT) begin
                        // msb of the fresh byte goes out first
                        next_data = hold_in[7];
                        next_shift = {hold_in[6:0], 1'b0};
                        next_oe = 1'b1;
                        next_count = 4'h0;
                    end else if (count == dmc_pkg::LAST_DATA_BIT) begin
                        // 9th bit: pin released, hold register reload requested
                        next_oe = 1'b0;
                        next_req = 1'b1;
                        next_count = dmc_pkg::NINTH_BIT;
                    end else begin
                        next_data = shift[7];
                        next_shift = {shift[6:0], 1'b0};
                        next_count = count + 4'h1;
                    end
                end
                default: begin
                    next_state = dmc_pkg::DMC_SYNC;
                    next_count = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= dmc_pkg::DMC_SYNC;
            count <= 4'h0;
            shift <= 8'h00;
            data <= 1'b0;
            oe <= 1'b0;
            req <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            shift <= next_shift;
            data <= next_data;
            oe <= next_oe;
            req <= next_req;
        end
    end

    assign reload_req_out = req;
    assign data_pin_out = data;
    assign data_pin_oe_out = oe;

endmodule

`default_nettype wire

// ==== src/dmc_mode_control.sv ====
// display channel mode control registers, pointer, reload path and mode switch
`timescale 1ns/1ns
`default_nettype none

module dmc_mode_control (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic one_way_link_clock_in,
    input wire logic two_wire_clock_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe_out,
    output logic [7:0] ram_raddr_out,
    input wire logic [7:0] ram_rdata_in,
    output logic [7:0] ram_waddr_out,
    output logic [7:0] ram_wdata_out,
    output logic ram_we_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////
    // pointer post increment with wrap inside the selected area
    function automatic logic [7:0] dmc_next_pointer(input logic [7:0] ptr, input logic full_size);
        logic [7:0] result;
        result = ptr + 8'h01;
        if (!full_size) begin
            // small area: locations above 127 stay free for the system
            result = (ptr[6:0] == dmc_pkg::SMALL_AREA_LIMIT[6:0]) ? 8'h00 : {1'b0, result[6:0]};
        end
        // in the full area the 8-bit sum wraps 255 to 0 by itself
        return result;
    endfunction

    ////////////////////////////////////////////////////////////////
    // two-wire clock synchroniser
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic scl_fall;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
        end else begin
            scl_meta <= two_wire_clock_pin_in;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
        end
    end

    // seen after the second flop so the mode bit moves on the third edge
    assign scl_fall = ~scl_sync & scl_prev;

    ////////////////////////////////////////////////////////////////
    // register file and buffer access
    logic [7:0] mode_control;
    logic [7:0] next_mode_control;
    logic [7:0] buffer_pointer;
    logic [7:0] next_buffer_pointer;
    logic [7:0] transmit_hold;
    logic [7:0] next_transmit_hold;
    logic [7:0] irq_status;
    logic [7:0] next_irq_status;
    logic [7:0] irq_mask;
    logic [7:0] next_irq_mask;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic hw_reload_pending;
    logic next_hw_reload_pending;
    logic [7:0] waddr;
    logic [7:0] next_waddr;
    logic [7:0] wdata;
    logic [7:0] next_wdata;
    logic we;
    logic next_we;

    logic tx_reload_req;
    logic tx_run;
    logic wr_mode;
    logic wr_pointer;
    logic wr_hold;
    logic wr_port;
    logic rd_port;
    logic rd_status;
    logic port_access;
    logic sw_select;
    logic full_size;
    logic reload_event;
    logic switch_event;

    assign sw_select = mode_control[dmc_pkg::BIT_SOFTWARE_HANDLING_SELECT];
    assign full_size = mode_control[dmc_pkg::BIT_BUFFER_SIZE_SELECT];
    // two-wire mode stops the one-way transmitter as well
    assign tx_run = mode_control[dmc_pkg::BIT_ONE_WAY_ENABLE] & ~mode_control[dmc_pkg::BIT_MODE_INDICATOR];

    assign wr_mode = reg_wr_in && (reg_addr_in == dmc_pkg::OFS_MODE_CONTROL);
    assign wr_pointer = reg_wr_in && (reg_addr_in == dmc_pkg::OFS_BUFFER_POINTER);
    assign wr_hold = reg_wr_in && (reg_addr_in == dmc_pkg::OFS_TRANSMIT_HOLD);
    assign wr_port = reg_wr_in && (reg_addr_in == dmc_pkg::OFS_BUFFER_DATA_PORT);
    assign rd_port = reg_rd_in && (reg_addr_in == dmc_pkg::OFS_BUFFER_DATA_PORT);
    assign rd_status = reg_rd_in && (reg_addr_in == dmc_pkg::OFS_IRQ_STATUS);
    assign port_access = wr_port | rd_port;

    assign reload_event = tx_reload_req & sw_select;
    // only a switch out of one-way mode counts, not ongoing two-wire traffic
    assign switch_event = scl_fall & ~mode_control[dmc_pkg::BIT_MODE_INDICATOR];

    always_comb begin
        next_mode_control = mode_control;
        next_buffer_pointer = buffer_pointer;
        next_transmit_hold = transmit_hold;
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        next_rdata = 8'h00;
        next_hw_reload_pending = hw_reload_pending;
        next_waddr = waddr;
        next_wdata = wdata;
        next_we = 1'b0;

        // software writes; flags are cleared by writing zero
        if (wr_mode) begin
            next_mode_control = reg_wdata_in & dmc_pkg::MODE_CONTROL_WMASK;
        end
        if (wr_hold) begin
            next_transmit_hold = reg_wdata_in;
        end
        if (reg_wr_in && (reg_addr_in == dmc_pkg::OFS_IRQ_MASK)) begin
            next_irq_mask = reg_wdata_in & dmc_pkg::IRQ_WMASK;
        end

        // buffer data port: every access moves the pointer on
        if (wr_pointer) begin
            next_buffer_pointer = reg_wdata_in;
        end else if (port_access) begin
            next_buffer_pointer = dmc_next_pointer(buffer_pointer, full_size);
        end
        if (wr_port) begin
            next_waddr = buffer_pointer;
            next_wdata = reg_wdata_in;
            next_we = 1'b1;
        end

        // hardware reload lands two cycles after the request, and waits while software accesses the port or writes the pointer
        if (tx_reload_req && !sw_select) begin
            next_hw_reload_pending = 1'b1;
        end
        if (hw_reload_pending && !port_access && !wr_pointer) begin
            next_transmit_hold = ram_rdata_in;
            next_buffer_pointer = dmc_next_pointer(buffer_pointer, full_size);
            next_hw_reload_pending = 1'b0;
        end
        if (!tx_run) begin
            next_hw_reload_pending = 1'b0;
        end

        // hardware sets win over software clears in the same cycle
        if (reload_event) begin
            next_mode_control[dmc_pkg::BIT_RELOAD_REQUEST_FLAG] = 1'b1;
        end
        if (switch_event) begin
            next_mode_control[dmc_pkg::BIT_MODE_SWITCH_FLAG] = 1'b1;
            next_mode_control[dmc_pkg::BIT_MODE_INDICATOR] = 1'b1;
        end

        // read data for the cycle after the strobe
        if (reg_rd_in) begin
            case (reg_addr_in)
                dmc_pkg::OFS_MODE_CONTROL: next_rdata = mode_control;
                dmc_pkg::OFS_BUFFER_POINTER: next_rdata = buffer_pointer;
                dmc_pkg::OFS_TRANSMIT_HOLD: next_rdata = transmit_hold;
                dmc_pkg::OFS_BUFFER_DATA_PORT: next_rdata = ram_rdata_in;
                dmc_pkg::OFS_IRQ_STATUS: next_rdata = irq_status;
                dmc_pkg::OFS_IRQ_MASK: next_rdata = irq_mask;
                default: next_rdata = 8'h00;
            endcase
        end

        // sticky status cleared by its read; a new event still lands
        if (rd_status) begin
            next_irq_status = 8'h00;
        end
        if (reload_event) begin
            next_irq_status[dmc_pkg::IRQ_BIT_RELOAD] = 1'b1;
        end
        if (switch_event) begin
            next_irq_status[dmc_pkg::IRQ_BIT_SWITCH] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_control <= dmc_pkg::MODE_CONTROL_RESET;
            buffer_pointer <= dmc_pkg::BUFFER_POINTER_RESET;
            transmit_hold <= dmc_pkg::TRANSMIT_HOLD_RESET;
            irq_status <= dmc_pkg::IRQ_STATUS_RESET;
            irq_mask <= dmc_pkg::IRQ_MASK_RESET;
            rdata <= 8'h00;
            hw_reload_pending <= 1'b0;
            waddr <= 8'h00;
            wdata <= 8'h00;
            we <= 1'b0;
        end else begin
            mode_control <= next_mode_control;
            buffer_pointer <= next_buffer_pointer;
            transmit_hold <= next_transmit_hold;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            rdata <= next_rdata;
            hw_reload_pending <= next_hw_reload_pending;
            waddr <= next_waddr;
            wdata <= next_wdata;
            we <= next_we;
        end
    end

    ////////////////////////////////////////////////////////////////
    // one-way transmitter
    dmc_one_way_tx u_tx (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .run_in(tx_run),
        .one_way_link_clock_in(one_way_link_clock_in),
        .hold_in(transmit_hold),
        .reload_req_out(tx_reload_req),
        .data_pin_out(data_pin_out),
        .data_pin_oe_out(data_pin_oe_out)
    );

    ////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata_out = rdata;
    // the buffer is read combinationally at the pointer address
    assign ram_raddr_out = buffer_pointer;
    assign ram_waddr_out = waddr;
    assign ram_wdata_out = wdata;
    assign ram_we_out = we;
    // the cpu reaches this line through the shared vector dmc_pkg::IRQ_VECTOR
    assign irq_out = |(irq_status & irq_mask);

endmodule

`default_nettype wire

// ==== testbench/dmc_mode_control_properties.sv ====
// port-level checks for the display channel mode control block
`timescale 1ns/1ns
`default_nettype none
module dmc_mode_control_properties (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic one_way_link_clock_in,
    input wire logic two_wire_clock_pin_in,
    input wire logic data_pin_out,
    input wire logic data_pin_oe_out,
    input wire logic [7:0] ram_raddr_out,
    input wire logic [7:0] ram_waddr_out,
    input wire logic [7:0] ram_wdata_out,
    input wire logic ram_we_out
);
    logic [3:0] link_rises;
    logic [3:0] next_link_rises;
    logic link_q1;
    logic link_q2;
    logic link_q3;
    logic run_shadow;
    logic next_run_shadow;
    logic [6:0] ptr_low;
    assign ptr_low = ram_raddr_out[6:0];
    ////////////////////////////////////////////////////////////////
    // same sampling of the link clock as the block, counted only while software has it running;
    // a hardware mode switch is not seen here, which can only let the count run ahead
    always_comb begin
        next_run_shadow = run_shadow;
        next_link_rises = link_rises;
        if (reg_wr_in && reg_addr_in == dmc_pkg::OFS_MODE_CONTROL) begin
            next_run_shadow = reg_wdata_in[dmc_pkg::BIT_ONE_WAY_ENABLE] & ~reg_wdata_in[dmc_pkg::BIT_MODE_INDICATOR];
        end
        if (!run_shadow) begin
            next_link_rises = 4'h0;
        end else if (link_q2 && !link_q3 && link_rises != 4'hf) begin
            next_link_rises = link_rises + 4'h1;
        end
    end
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link_rises <= 4'h0;
            run_shadow <= 1'b0;
            link_q1 <= 1'b0;
            link_q2 <= 1'b0;
            link_q3 <= 1'b0;
        end else begin
            link_rises <= next_link_rises;
            run_shadow <= next_run_shadow;
            link_q1 <= one_way_link_clock_in;
            link_q2 <= link_q1;
            link_q3 <= link_q2;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    reserved_bits_zero_a: assert property (reg_rd_in && reg_addr_in == dmc_pkg::OFS_MODE_CONTROL
        |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[4] == 1'b0) else $error("reserved bits read nonzero");
    idle_rdata_zero_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data outside read slot");
    pointer_step_a: assert property (reg_rd_in && reg_addr_in == dmc_pkg::OFS_BUFFER_DATA_PORT
        |=> ram_raddr_out == $past(ram_raddr_out) + 8'h01 || ram_raddr_out == {1'b0, $past(ptr_low) + 7'h01})
        else $error("pointer did not step after port read");
    port_write_a: assert property (reg_wr_in && reg_addr_in == dmc_pkg::OFS_BUFFER_DATA_PORT
        |=> ram_we_out && ram_waddr_out == $past(ram_raddr_out) && ram_wdata_out == $past(reg_wdata_in))
        else $error("port write not passed to buffer");
    write_cause_a: assert property (ram_we_out
        |-> $past(reg_wr_in) && $past(reg_addr_in) == dmc_pkg::OFS_BUFFER_DATA_PORT)
        else $error("buffer write without port write");
    sync_count_a: assert property (data_pin_oe_out |-> link_rises >= 4'ha)
        else $error("data pin driven during synchronisation");
    drive_on_edge_a: assert property ($rose(data_pin_oe_out) |-> one_way_link_clock_in)
        else $error("data pin enabled away from link rise");
    data_hold_a: assert property (data_pin_oe_out && $past(data_pin_oe_out) && $changed(data_pin_out)
        |-> one_way_link_clock_in) else $error("data bit changed away from link rise");
    switch_release_a: assert property ($fell(two_wire_clock_pin_in) |-> ##[0:5] !data_pin_oe_out)
        else $error("one-way output kept after mode switch");
endmodule
bind dmc_mode_control dmc_mode_control_properties chk_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in),
    .reg_rdata_out(reg_rdata_out), .one_way_link_clock_in(one_way_link_clock_in),
    .two_wire_clock_pin_in(two_wire_clock_pin_in), .data_pin_out(data_pin_out), .data_pin_oe_out(data_pin_oe_out),
    .ram_raddr_out(ram_raddr_out), .ram_waddr_out(ram_waddr_out), .ram_wdata_out(ram_wdata_out),
    .ram_we_out(ram_we_out));
`default_nettype wire

// ==== testbench/dmc_host_model.sv ====
// host model: makes link clock frames, drops the two-wire clock, captures bytes
`timescale 1ns/1ns
`default_nettype none
module dmc_host_model (
    input wire logic sda_in,
    input wire logic oe_in,
    output logic link_clk_out,
    output logic twc_out
);
    logic [7:0] sh;
    logic [7:0] got[$];
    int k;
    int rel_bad;
    initial begin
        link_clk_out = 1'b0;
        twc_out = 1'b1;
        sh = 8'h00;
        k = 0;
        rel_bad = 0;
    end
    // clock rests low between frames; bits are taken late in the high phase
    task automatic run_link(input int n);
        repeat (n) begin
            #63 link_clk_out <= 1'b1;
            #62 link_clk_out <= 1'b0;
            k = k + 1;
            if (k <= 9 || (k - 10) % 9 == 8) begin
                if (oe_in !== 1'b0) rel_bad = rel_bad + 1;
            end else begin
                sh = {sh[6:0], sda_in};
                if ((k - 10) % 9 == 7) got.push_back(sh);
            end
        end
    endtask
    task automatic drop_twc();
        twc_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb_dmc_mode_control.sv ====
// self-checking bench for the display channel mode control block
`timescale 1ns/1ns
`default_nettype none
module tb_dmc_mode_control;
    logic ref_clk_in;
    logic rstn_in;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic link_clk;
    logic twc;
    logic data_pin;
    logic data_oe;
    logic sda;
    logic [7:0] raddr;
    logic [7:0] waddr;
    logic [7:0] ram_wd;
    logic ram_we;
    logic irq;
    logic [7:0] ram [256];
    logic [7:0] v;
    int fails;
    int tests_run;
    assign sda = data_oe ? data_pin : 1'b1;
    dmc_mode_control DUT (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .one_way_link_clock_in(link_clk),
        .two_wire_clock_pin_in(twc), .data_pin_out(data_pin), .data_pin_oe_out(data_oe), .ram_raddr_out(raddr),
        .ram_rdata_in(ram[raddr]), .ram_waddr_out(waddr), .ram_wdata_out(ram_wd), .ram_we_out(ram_we),
        .irq_out(irq));
    dmc_host_model host (.sda_in(sda), .oe_in(data_oe), .link_clk_out(link_clk), .twc_out(twc));
    always @(posedge ref_clk_in) begin
        if (ram_we) ram[waddr] <= ram_wd;
    end
    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        @(negedge ref_clk_in);
        v = rdata;
        chk(v, exp);
    endtask
    task automatic irq_chk(input logic exp);
        @(negedge ref_clk_in);
        chk({7'h00, irq}, {7'h00, exp});
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fails = fails + 1;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        rstn_in = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        fails = 0;
        tests_run = 0;
        for (int i = 0; i < 256; i++) ram[i] = 8'(i) ^ 8'h1d;
        repeat (8) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        rd_chk(dmc_pkg::OFS_MODE_CONTROL, dmc_pkg::MODE_CONTROL_RESET);
        rd_chk(dmc_pkg::OFS_BUFFER_POINTER, dmc_pkg::BUFFER_POINTER_RESET);
        rd_chk(dmc_pkg::OFS_IRQ_STATUS, dmc_pkg::IRQ_STATUS_RESET);
        rd_chk(4'hf, 8'h00);
        wr_reg(dmc_pkg::OFS_MODE_CONTROL, 8'hff);
        rd_chk(dmc_pkg::OFS_MODE_CONTROL, 8'hff & dmc_pkg::MODE_CONTROL_WMASK);
        wr_reg(dmc_pkg::OFS_MODE_CONTROL, 8'h00);
        rd_chk(dmc_pkg::OFS_IRQ_STATUS, 8'h00);
        // pointer wrap in the small and the large area
        wr_reg(dmc_pkg::OFS_BUFFER_POINTER, 8'h7f);
        rd_chk(dmc_pkg::OFS_BUFFER_DATA_PORT, 8'h7f ^ 8'h1d);
        rd_chk(dmc_pkg::OFS_BUFFER_POINTER, 8'h00);
        wr_reg(dmc_pkg::OFS_MODE_CONTROL, 8'h40);
        wr_reg(dmc_pkg::OFS_BUFFER_POINTER, 8'h7f);
        rd_chk(dmc_pkg::OFS_BUFFER_DATA_PORT, 8'h7f ^ 8'h1d);
        rd_chk(dmc_pkg::OFS_BUFFER_POINTER, 8'h80);
        wr_reg(dmc_pkg::OFS_BUFFER_POINTER, 8'hff);
        rd_chk(dmc_pkg::OFS_BUFFER_DATA_PORT, 8'hff ^ 8'h1d);
        rd_chk(dmc_pkg::OFS_BUFFER_POINTER, 8'h00);
        wr_reg(dmc_pkg::OFS_BUFFER_DATA_PORT, 8'h5a);
        rd_chk(dmc_pkg::OFS_BUFFER_POINTER, 8'h01);
        chk(ram[0], 8'h5a);
        // link clock ignored while disabled
        wr_reg(dmc_pkg::OFS_MODE_CONTROL, 8'h00);
        host.run_link(12);
        chk(8'(host.got.size()), 8'h00);
        rd_chk(dmc_pkg::OFS_BUFFER_POINTER, 8'h01);
        // hardware reload from the buffer
        wr_reg(dmc_pkg::OFS_BUFFER_POINTER, 8'h00);
        wr_reg(dmc_pkg::OFS_MODE_CONTROL, 8'h04);
        host.k = 0;
        host.run_link(27);
        chk(host.got[0], 8'h5a);
        chk(host.got[1], 8'h1c);
        rd_chk(dmc_pkg::OFS_BUFFER_POINTER, 8'h03);
        rd_chk(dmc_pkg::OFS_TRANSMIT_HOLD, 8'h02 ^ 8'h1d);
        rd_chk(dmc_pkg::OFS_MODE_CONTROL, 8'h04);
        rd_chk(dmc_pkg::OFS_IRQ_STATUS, 8'h00);
        // software reload with interrupt, masked first
        wr_reg(dmc_pkg::OFS_MODE_CONTROL, 8'h00);
        wr_reg(dmc_pkg::OFS_MODE_CONTROL, 8'h24);
        host.k = 0;
        host.got.delete();
        host.run_link(9);
        irq_chk(1'b0);
        wr_reg(dmc_pkg::OFS_IRQ_MASK, 8'h01);
        irq_chk(1'b1);
        rd_chk(dmc_pkg::OFS_MODE_CONTROL, 8'h2c);
        wr_reg(dmc_pkg::OFS_TRANSMIT_HOLD, 8'hc3);
        wr_reg(dmc_pkg::OFS_MODE_CONTROL, 8'h24);
        rd_chk(dmc_pkg::OFS_MODE_CONTROL, 8'h24);
        rd_chk(dmc_pkg::OFS_IRQ_STATUS, 8'h01);
        rd_chk(dmc_pkg::OFS_IRQ_STATUS, 8'h00);
        irq_chk(1'b0);
        host.run_link(9);
        chk(host.got[0], 8'hc3);
        rd_chk(dmc_pkg::OFS_MODE_CONTROL, 8'h2c);
        // switch to two-wire mode
        // switch while a data bit is on the pin, so the release is really exercised
        host.run_link(1);
        wr_reg(dmc_pkg::OFS_IRQ_MASK, 8'h03);
        host.drop_twc();
        repeat (2) @(posedge ref_clk_in);
        rd_chk(dmc_pkg::OFS_MODE_CONTROL, 8'h2f);
        irq_chk(1'b1);
        rd_chk(dmc_pkg::OFS_IRQ_STATUS, 8'h03);
        wr_reg(dmc_pkg::OFS_MODE_CONTROL, 8'h25);
        rd_chk(dmc_pkg::OFS_MODE_CONTROL, 8'h25);
        host.k = 0;
        host.run_link(12);
        chk(8'(host.rel_bad), 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
